// >>> logic/opdec_pkg.sv
package opdec_pkg;

  // Operation handed to the datapath
  typedef enum logic [3:0] {
    ALU_NONE,
    ALU_ADD,
    ALU_ADD_CY,
    ALU_SUB_BW,
    ALU_AND,
    ALU_OR,
    ALU_XOR,
    ALU_ROL_CY,
    ALU_ROR_CY,
    ALU_COPY
  } alu_op_t;

  // Where the operand comes from
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_REG,
    SRC_DIR,
    SRC_IND,
    SRC_IMM,
    SRC_ACC
  } src_sel_t;

  // Where the result goes
  typedef enum logic [1:0] {
    DST_NONE,
    DST_ACC,
    DST_DIR,
    DST_REG
  } dst_sel_t;

  // One line of the opcode table
  typedef struct packed {
    logic       known;
    alu_op_t    alu;
    src_sel_t   src;
    dst_sel_t   dst;
    logic [1:0] len;
    logic [1:0] cyc;
  } dec_entry_t;

  // Lengths in bytes and execution cycles
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;

  // Timer and reset values
  localparam logic [1:0] CNT_IDLE    = 2'h0;
  localparam logic [1:0] CNT_LAST    = 2'h1;
  localparam logic [1:0] LEFT_RST    = 2'h0;
  localparam logic [2:0] REG_IDX_RST = 3'h0;
  localparam logic [7:0] BYTE_RST    = 8'h00;

  // Index fields inside an opcode
  localparam int unsigned REG_IDX_MSB = 2;
  localparam int unsigned PTR_IDX_BIT = 0;
  localparam logic [7:0]  RANGE8_MASK = 8'hf8;
  localparam logic [7:0]  RANGE2_MASK = 8'hfe;

  // Opcode bases; ranges of eight or two start here
  localparam logic [7:0] OPC_ADD_REG   = 8'h28;
  localparam logic [7:0] OPC_ADD_DIR   = 8'h25;
  localparam logic [7:0] OPC_ADD_IND   = 8'h26;
  localparam logic [7:0] OPC_ADD_IMM   = 8'h24;
  localparam logic [7:0] OPC_ADCY_REG  = 8'h38;
  localparam logic [7:0] OPC_ADCY_DIR  = 8'h35;
  localparam logic [7:0] OPC_ADCY_IND  = 8'h36;
  localparam logic [7:0] OPC_ADCY_IMM  = 8'h34;
  localparam logic [7:0] OPC_SBW_REG   = 8'h98;
  localparam logic [7:0] OPC_SBW_DIR   = 8'h95;
  localparam logic [7:0] OPC_SBW_IND   = 8'h96;
  localparam logic [7:0] OPC_SBW_IMM   = 8'h94;
  localparam logic [7:0] OPC_AND_REG   = 8'h58;
  localparam logic [7:0] OPC_AND_DIR   = 8'h55;
  localparam logic [7:0] OPC_AND_IND   = 8'h56;
  localparam logic [7:0] OPC_AND_IMM   = 8'h54;
  localparam logic [7:0] OPC_AND_TO_DA = 8'h52;
  localparam logic [7:0] OPC_AND_TO_DI = 8'h53;
  localparam logic [7:0] OPC_OR_REG    = 8'h48;
  localparam logic [7:0] OPC_OR_DIR    = 8'h45;
  localparam logic [7:0] OPC_OR_IND    = 8'h46;
  localparam logic [7:0] OPC_OR_IMM    = 8'h44;
  localparam logic [7:0] OPC_OR_TO_DA  = 8'h42;
  localparam logic [7:0] OPC_OR_TO_DI  = 8'h43;
  localparam logic [7:0] OPC_XOR_REG   = 8'h68;
  localparam logic [7:0] OPC_XOR_DIR   = 8'h65;
  localparam logic [7:0] OPC_XOR_IND   = 8'h66;
  localparam logic [7:0] OPC_XOR_IMM   = 8'h64;
  localparam logic [7:0] OPC_XOR_TO_DA = 8'h62;
  localparam logic [7:0] OPC_XOR_TO_DI = 8'h63;
  localparam logic [7:0] OPC_ROL_CY    = 8'h33;
  localparam logic [7:0] OPC_ROR_CY    = 8'h13;
  localparam logic [7:0] OPC_CP_IND_DR = 8'h86;
  localparam logic [7:0] OPC_CP_DIR_DR = 8'h85;
  localparam logic [7:0] OPC_CP_DIR_RG = 8'ha8;
  localparam logic [7:0] OPC_CP_IMM_RG = 8'h78;
  localparam logic [7:0] OPC_CP_RG_DIR = 8'h88;

  // Opcodes outside the table pass as one byte, one cycle
  localparam dec_entry_t ENTRY_NONE =
    '{1'b0, ALU_NONE, SRC_NONE, DST_NONE, LEN_ONE, CYC_ONE};

  // Member of a range of eight
  function automatic logic in_r8(input logic [7:0] op, input logic [7:0] base);
    return (op & RANGE8_MASK) == base;
  endfunction

  // Member of a range of two
  function automatic logic in_r2(input logic [7:0] op, input logic [7:0] base);
    return (op & RANGE2_MASK) == base;
  endfunction

  // Build a known table line
  function automatic dec_entry_t mk(input alu_op_t a, input src_sel_t s,
                                    input dst_sel_t d, input logic [1:0] l,
                                    input logic [1:0] c);
    return '{1'b1, a, s, d, l, c};
  endfunction

endpackage

// >>> logic/operand_index.sv
`timescale 1ns/1ps
module operand_index
  import opdec_pkg::*;
(
  input  wire logic [7:0] opcode,
  input  wire src_sel_t   src_sel,
  input  wire dst_sel_t   dst_sel,
  output logic      [2:0] reg_index,
  output logic            ptr_index
);

  logic reg_used;
  logic ptr_used;

  // (RULE17) Index from opcode
  // Zero when unused, so stale bits never reach the register file
  always_comb
  begin
    reg_used  = (src_sel == SRC_REG) || (dst_sel == DST_REG);
    ptr_used  = (src_sel == SRC_IND);
    reg_index = reg_used ? opcode[REG_IDX_MSB:0] : REG_IDX_RST;
    ptr_index = ptr_used & opcode[PTR_IDX_BIT];
  end

endmodule

// >>> logic/exec_timer.sv
`timescale 1ns/1ps
module exec_timer
  import opdec_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [1:0] cycles,
  output logic            busy,
  output logic            done
);

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;

  // Load on start, then count down to idle
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (start)
    begin
      cnt_nxt = cycles;
    end
    else if (cnt_r != CNT_IDLE)
    begin
      cnt_nxt = cnt_r - CNT_LAST;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_r <= CNT_IDLE;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  // Busy for exactly the loaded count
  assign busy = (cnt_r != CNT_IDLE);
  assign done = (cnt_r == CNT_LAST);

endmodule

// >>> logic/alu_logic_move_opcode_decoder.sv
`timescale 1ns/1ps
// Function
// (RULE1) Add forms: register, direct, indirect, one cycle
// (RULE2) Add with carry: register, direct, immediate
// (RULE3) Subtract with borrow: register, direct, indirect
// (RULE4) 53h: three bytes, immediate into direct
// (RULE5) And into accumulator: register, indirect, immediate
// (RULE6) 52h: accumulator and into direct byte
// (RULE7) 43h: or immediate into direct, two cycles
// (RULE8) Or into accumulator: register, indirect, immediate
// (RULE9) 63h: xor immediate into direct, two cycles
// (RULE10) Xor into accumulator: register, direct, indirect
// (RULE11) 33h and 13h rotate through carry
// (RULE12) 86h-87h indirect to direct, two cycles
// (RULE13) 85h direct to direct, three bytes
// (RULE14) A8h-AFh direct to register, two cycles
// (RULE15) 78h-7Fh immediate to register, one cycle
// (RULE16) 88h-8Fh register to direct, two cycles
// (RULE17) Register and pointer index from opcode
module alu_logic_move_opcode_decoder
  import opdec_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       opcode_valid,
  input  wire logic [7:0] opcode,
  output logic            opcode_ready,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_in,
  output logic            byte_ready,
  output logic            dec_valid,
  output logic            known,
  output alu_op_t         alu_op,
  output src_sel_t        src_sel,
  output dst_sel_t        dst_sel,
  output logic      [1:0] instr_len,
  output logic      [1:0] exec_cycles,
  output logic      [2:0] reg_index,
  output logic            ptr_index,
  output logic      [7:0] operand1,
  output logic      [7:0] operand2,
  output logic            exec_start,
  output logic            exec_busy,
  output logic            exec_done
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_EXEC
  } state_t;

  state_t     state_r;
  state_t     state_nxt;
  dec_entry_t ent_r;
  dec_entry_t ent_nxt;
  dec_entry_t lk_ent;
  logic [2:0] reg_idx_r;
  logic [2:0] reg_idx_nxt;
  logic       ptr_idx_r;
  logic       ptr_idx_nxt;
  logic [2:0] reg_idx_w;
  logic       ptr_idx_w;
  logic [1:0] left_r;
  logic [1:0] left_nxt;
  logic [7:0] op1_r;
  logic [7:0] op1_nxt;
  logic [7:0] op2_r;
  logic [7:0] op2_nxt;
  logic       dec_valid_r;
  logic       dec_valid_nxt;
  logic       start_r;
  logic       start_nxt;
  logic       first_byte;
  logic       opcode_take;
  logic       byte_take;

  // Opcode table; the order of the chain does not matter as no
  // two entries overlap
  function automatic dec_entry_t lookup(input logic [7:0] op);
    dec_entry_t e;
    e = ENTRY_NONE;
    // (RULE1) Add forms
    if (in_r8(op, OPC_ADD_REG)) e = mk(ALU_ADD, SRC_REG, DST_ACC, LEN_ONE, CYC_ONE);
    else if (op == OPC_ADD_DIR) e = mk(ALU_ADD, SRC_DIR, DST_ACC, LEN_TWO, CYC_ONE);
    else if (in_r2(op, OPC_ADD_IND)) e = mk(ALU_ADD, SRC_IND, DST_ACC, LEN_ONE, CYC_ONE);
    else if (op == OPC_ADD_IMM) e = mk(ALU_ADD, SRC_IMM, DST_ACC, LEN_TWO, CYC_ONE);
    // (RULE2) Add with carry
    else if (in_r8(op, OPC_ADCY_REG)) e = mk(ALU_ADD_CY, SRC_REG, DST_ACC, LEN_ONE, CYC_ONE);
    else if (op == OPC_ADCY_DIR) e = mk(ALU_ADD_CY, SRC_DIR, DST_ACC, LEN_TWO, CYC_ONE);
    else if (in_r2(op, OPC_ADCY_IND)) e = mk(ALU_ADD_CY, SRC_IND, DST_ACC, LEN_ONE, CYC_ONE);
    else if (op == OPC_ADCY_IMM) e = mk(ALU_ADD_CY, SRC_IMM, DST_ACC, LEN_TWO, CYC_ONE);
    // (RULE3) Subtract with borrow
    else if (in_r8(op, OPC_SBW_REG)) e = mk(ALU_SUB_BW, SRC_REG, DST_ACC, LEN_ONE, CYC_ONE);
    else if (op == OPC_SBW_DIR) e = mk(ALU_SUB_BW, SRC_DIR, DST_ACC, LEN_TWO, CYC_ONE);
    else if (in_r2(op, OPC_SBW_IND)) e = mk(ALU_SUB_BW, SRC_IND, DST_ACC, LEN_ONE, CYC_ONE);
    else if (op == OPC_SBW_IMM) e = mk(ALU_SUB_BW, SRC_IMM, DST_ACC, LEN_TWO, CYC_ONE);
    // (RULE5) And into accumulator
    else if (in_r8(op, OPC_AND_REG)) e = mk(ALU_AND, SRC_REG, DST_ACC, LEN_ONE, CYC_ONE);
    else if (op == OPC_AND_DIR) e = mk(ALU_AND, SRC_DIR, DST_ACC, LEN_TWO, CYC_ONE);
    else if (in_r2(op, OPC_AND_IND)) e = mk(ALU_AND, SRC_IND, DST_ACC, LEN_ONE, CYC_ONE);
    else if (op == OPC_AND_IMM) e = mk(ALU_AND, SRC_IMM, DST_ACC, LEN_TWO, CYC_ONE);
    // (RULE6) And to direct byte
    else if (op == OPC_AND_TO_DA) e = mk(ALU_AND, SRC_ACC, DST_DIR, LEN_TWO, CYC_ONE);
    // (RULE4) And immediate to direct
    else if (op == OPC_AND_TO_DI) e = mk(ALU_AND, SRC_IMM, DST_DIR, LEN_THREE, CYC_TWO);
    // (RULE8) Or into accumulator, then 42h accumulator or into direct byte
    else if (in_r8(op, OPC_OR_REG)) e = mk(ALU_OR, SRC_REG, DST_ACC, LEN_ONE, CYC_ONE);
    else if (op == OPC_OR_DIR) e = mk(ALU_OR, SRC_DIR, DST_ACC, LEN_TWO, CYC_ONE);
    else if (in_r2(op, OPC_OR_IND)) e = mk(ALU_OR, SRC_IND, DST_ACC, LEN_ONE, CYC_ONE);
    else if (op == OPC_OR_IMM) e = mk(ALU_OR, SRC_IMM, DST_ACC, LEN_TWO, CYC_ONE);
    else if (op == OPC_OR_TO_DA) e = mk(ALU_OR, SRC_ACC, DST_DIR, LEN_TWO, CYC_ONE);
    // (RULE7) Or immediate to direct
    else if (op == OPC_OR_TO_DI) e = mk(ALU_OR, SRC_IMM, DST_DIR, LEN_THREE, CYC_TWO);
    // (RULE10) Xor into accumulator, then 62h accumulator xor into direct byte
    else if (in_r8(op, OPC_XOR_REG)) e = mk(ALU_XOR, SRC_REG, DST_ACC, LEN_ONE, CYC_ONE);
    else if (op == OPC_XOR_DIR) e = mk(ALU_XOR, SRC_DIR, DST_ACC, LEN_TWO, CYC_ONE);
    else if (in_r2(op, OPC_XOR_IND)) e = mk(ALU_XOR, SRC_IND, DST_ACC, LEN_ONE, CYC_ONE);
    else if (op == OPC_XOR_IMM) e = mk(ALU_XOR, SRC_IMM, DST_ACC, LEN_TWO, CYC_ONE);
    else if (op == OPC_XOR_TO_DA) e = mk(ALU_XOR, SRC_ACC, DST_DIR, LEN_TWO, CYC_ONE);
    // (RULE9) Xor immediate to direct
    else if (op == OPC_XOR_TO_DI) e = mk(ALU_XOR, SRC_IMM, DST_DIR, LEN_THREE, CYC_TWO);
    // (RULE11) Rotates through carry
    else if (op == OPC_ROL_CY) e = mk(ALU_ROL_CY, SRC_ACC, DST_ACC, LEN_ONE, CYC_ONE);
    else if (op == OPC_ROR_CY) e = mk(ALU_ROR_CY, SRC_ACC, DST_ACC, LEN_ONE, CYC_ONE);
    // (RULE12) Indirect to direct
    else if (in_r2(op, OPC_CP_IND_DR)) e = mk(ALU_COPY, SRC_IND, DST_DIR, LEN_TWO, CYC_TWO);
    // (RULE13) Direct to direct
    else if (op == OPC_CP_DIR_DR) e = mk(ALU_COPY, SRC_DIR, DST_DIR, LEN_THREE, CYC_TWO);
    // (RULE14) Direct to register
    else if (in_r8(op, OPC_CP_DIR_RG)) e = mk(ALU_COPY, SRC_DIR, DST_REG, LEN_TWO, CYC_TWO);
    // (RULE15) Immediate to register
    else if (in_r8(op, OPC_CP_IMM_RG)) e = mk(ALU_COPY, SRC_IMM, DST_REG, LEN_TWO, CYC_ONE);
    // (RULE16) Register to direct
    else if (in_r8(op, OPC_CP_RG_DIR)) e = mk(ALU_COPY, SRC_REG, DST_DIR, LEN_TWO, CYC_TWO);
    return e;
  endfunction

  assign lk_ent = lookup(opcode);

  // (RULE17) Index extraction
  operand_index u_index (
    .opcode    (opcode),
    .src_sel   (lk_ent.src),
    .dst_sel   (lk_ent.dst),
    .reg_index (reg_idx_w),
    .ptr_index (ptr_idx_w)
  );

  // Handshakes; only one opcode in flight, so no queue is needed
  assign opcode_ready = (state_r == ST_IDLE);
  assign byte_ready   = (state_r == ST_FETCH);
  assign opcode_take  = opcode_valid & opcode_ready;
  assign byte_take    = byte_valid & byte_ready;
  assign first_byte   = (left_r == (ent_r.len - LEN_ONE));

  // Sequencer: take opcode, collect operand bytes, then execute
  always_comb
  begin
    state_nxt     = state_r;
    ent_nxt       = ent_r;
    reg_idx_nxt   = reg_idx_r;
    ptr_idx_nxt   = ptr_idx_r;
    left_nxt      = left_r;
    op1_nxt       = op1_r;
    op2_nxt       = op2_r;
    dec_valid_nxt = 1'b0;
    start_nxt     = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (opcode_take)
        begin
          ent_nxt       = lk_ent;
          reg_idx_nxt   = reg_idx_w;
          ptr_idx_nxt   = ptr_idx_w;
          op1_nxt       = BYTE_RST;
          op2_nxt       = BYTE_RST;
          dec_valid_nxt = 1'b1;
          left_nxt      = lk_ent.len - LEN_ONE;
          if (lk_ent.len == LEN_ONE)
          begin
            state_nxt = ST_EXEC;
            start_nxt = 1'b1;
          end
          else
          begin
            state_nxt = ST_FETCH;
          end
        end
      end
      ST_FETCH:
      begin
        if (byte_take)
        begin
          // First operand byte lands in operand1
          if (first_byte)
          begin
            op1_nxt = byte_in;
          end
          else
          begin
            op2_nxt = byte_in;
          end
          left_nxt = left_r - LEN_ONE;
          if (left_r == LEN_ONE)
          begin
            state_nxt = ST_EXEC;
            start_nxt = 1'b1;
          end
        end
      end
      ST_EXEC:
      begin
        if (exec_done)
        begin
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_r     <= ST_IDLE;
      ent_r       <= ENTRY_NONE;
      reg_idx_r   <= REG_IDX_RST;
      ptr_idx_r   <= 1'b0;
      left_r      <= LEFT_RST;
      op1_r       <= BYTE_RST;
      op2_r       <= BYTE_RST;
      dec_valid_r <= 1'b0;
      start_r     <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      ent_r       <= ent_nxt;
      reg_idx_r   <= reg_idx_nxt;
      ptr_idx_r   <= ptr_idx_nxt;
      left_r      <= left_nxt;
      op1_r       <= op1_nxt;
      op2_r       <= op2_nxt;
      dec_valid_r <= dec_valid_nxt;
      start_r     <= start_nxt;
    end
  end

  // Cycle count of the decoded instruction
  exec_timer u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (start_r),
    .cycles  (ent_r.cyc),
    .busy    (exec_busy),
    .done    (exec_done)
  );

  // Decoded fields straight from flops
  assign dec_valid   = dec_valid_r;
  assign known       = ent_r.known;
  assign alu_op      = ent_r.alu;
  assign src_sel     = ent_r.src;
  assign dst_sel     = ent_r.dst;
  assign instr_len   = ent_r.len;
  assign exec_cycles = ent_r.cyc;
  assign reg_index   = reg_idx_r;
  assign ptr_index   = ptr_idx_r;
  assign operand1    = op1_r;
  assign operand2    = op2_r;
  assign exec_start  = start_r;

  // Checks on the decode and the timing
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_add_reg_decode: assert property ( // RULE1
    opcode_take && in_r8(opcode, OPC_ADD_REG) |=> dec_valid && alu_op == ALU_ADD
      && src_sel == SRC_REG && instr_len == LEN_ONE && exec_cycles == CYC_ONE
      && reg_index == $past(opcode[2:0]))
    else $error("add register form decoded wrongly");

  a_addcy_direct: assert property ( // RULE2
    opcode_take && opcode == OPC_ADCY_DIR |=> alu_op == ALU_ADD_CY
      && src_sel == SRC_DIR && instr_len == LEN_TWO && byte_ready)
    else $error("add with carry direct decoded wrongly");

  a_subbw_indirect: assert property ( // RULE3
    opcode_take && in_r2(opcode, OPC_SBW_IND) |=> alu_op == ALU_SUB_BW
      && src_sel == SRC_IND && ptr_index == $past(opcode[0]))
    else $error("subtract indirect decoded wrongly");

  a_and_imm_direct: assert property ( // RULE4
    opcode_take && opcode == OPC_AND_TO_DI |=> alu_op == ALU_AND && src_sel == SRC_IMM
      && dst_sel == DST_DIR && instr_len == LEN_THREE && exec_cycles == CYC_TWO)
    else $error("and immediate to direct decoded wrongly");

  a_and_acc_direct: assert property ( // RULE6
    opcode_take && opcode == OPC_AND_TO_DA |=> src_sel == SRC_ACC
      && dst_sel == DST_DIR && instr_len == LEN_TWO && exec_cycles == CYC_ONE)
    else $error("and accumulator to direct decoded wrongly");

  a_or_xor_direct: assert property ( // RULE7
    opcode_take && (opcode == OPC_OR_TO_DI || opcode == OPC_XOR_TO_DI)
      |=> instr_len == LEN_THREE && exec_cycles == CYC_TWO && dst_sel == DST_DIR)
    else $error("or or xor immediate to direct decoded wrongly");

  a_rotate_carry: assert property ( // RULE11
    opcode_take && opcode == OPC_ROL_CY |=> alu_op == ALU_ROL_CY
      && instr_len == LEN_ONE ##1 exec_busy && exec_done ##1 opcode_ready)
    else $error("rotate left through carry wrongly handled");

  a_copy_reg_dir: assert property ( // RULE16
    opcode_take && in_r8(opcode, OPC_CP_RG_DIR) |=> alu_op == ALU_COPY
      && dst_sel == DST_DIR && exec_cycles == CYC_TWO
      && reg_index == $past(opcode[2:0]))
    else $error("register to direct copy decoded wrongly");

  a_copy_imm_reg: assert property ( // RULE15
    opcode_take && in_r8(opcode, OPC_CP_IMM_RG) |=> dst_sel == DST_REG
      && src_sel == SRC_IMM && instr_len == LEN_TWO && exec_cycles == CYC_ONE)
    else $error("immediate to register copy decoded wrongly");

  a_two_cycle_exec: assert property ( // RULE13
    exec_start && exec_cycles == CYC_TWO |=> exec_busy [*2] ##1 !exec_busy)
    else $error("two cycle instruction not busy for two cycles");

  a_one_cycle_exec: assert property ( // RULE5
    exec_start && exec_cycles == CYC_ONE |=> exec_busy ##1 !exec_busy)
    else $error("one cycle instruction not busy for one cycle");

  c_three_byte: cover property (opcode_take && lk_ent.len == LEN_THREE ##[1:8] exec_done);
  c_fetch_stall: cover property (byte_ready && !byte_valid ##1 byte_take);
  c_unknown_op: cover property (dec_valid && !known);
  c_back_to_back: cover property (exec_done ##1 opcode_take);

endmodule

// >>> tb/fetch_model.sv
`timescale 1ns/1ps
module fetch_model
(
  input  wire logic       sys_clk,
  input  wire logic       opcode_ready,
  input  wire logic       byte_ready,
  output logic            opcode_valid,
  output logic      [7:0] opcode,
  output logic            byte_valid,
  output logic      [7:0] byte_in
);
  // Idle lines at time zero
  initial
  begin
    opcode_valid = 1'b0;
    opcode       = 8'h00;
    byte_valid   = 1'b0;
    byte_in      = 8'h00;
  end

  // Move k edges on, then just past the edge; k of 0 stays put
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    if (k > 0)
      #1;
  endtask

  // Offer one instruction; gap cycles of stall before each unit
  task automatic send(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b,
                      input int n, input int gap);
    step(gap + 1);
    opcode_valid = 1'b1;
    opcode       = op;
    while (opcode_ready !== 1'b1)
      step(1);
    step(1);
    // Released lines show the inverse, so a stale value never looks valid
    opcode_valid = 1'b0;
    opcode       = ~op;
    for (int i = 1; i < n; i++)
    begin
      step(gap);
      byte_valid = 1'b1;
      byte_in    = (i == 1) ? a : b;
      while (byte_ready !== 1'b1)
        step(1);
      step(1);
      byte_valid = 1'b0;
      byte_in    = ~byte_in;
    end
  endtask
endmodule

// >>> tb/alu_logic_move_opcode_decoder_test.sv
`timescale 1ns/1ps
module alu_logic_move_opcode_decoder_test;
  import opdec_pkg::*;
  logic       sys_clk;
  logic       rst;
  logic       opcode_valid;
  logic [7:0] opcode;
  logic       opcode_ready;
  logic       byte_valid;
  logic [7:0] byte_in;
  logic       byte_ready;
  logic       dec_valid;
  logic       known;
  alu_op_t    alu_op;
  src_sel_t   src_sel;
  dst_sel_t   dst_sel;
  logic [1:0] instr_len;
  logic [1:0] exec_cycles;
  logic [2:0] reg_index;
  logic       ptr_index;
  logic [7:0] operand1;
  logic [7:0] operand2;
  logic       exec_start;
  logic       exec_busy;
  logic       exec_done;
  int         n_mismatch;
  int         check_count;

  alu_logic_move_opcode_decoder alu_logic_move_opcode_decoder_inst (
    .sys_clk(sys_clk), .rst(rst), .opcode_valid(opcode_valid), .opcode(opcode),
    .opcode_ready(opcode_ready), .byte_valid(byte_valid), .byte_in(byte_in),
    .byte_ready(byte_ready), .dec_valid(dec_valid), .known(known), .alu_op(alu_op),
    .src_sel(src_sel), .dst_sel(dst_sel), .instr_len(instr_len),
    .exec_cycles(exec_cycles), .reg_index(reg_index), .ptr_index(ptr_index),
    .operand1(operand1), .operand2(operand2), .exec_start(exec_start),
    .exec_busy(exec_busy), .exec_done(exec_done));

  fetch_model fetch_model_inst (
    .sys_clk(sys_clk), .opcode_ready(opcode_ready), .byte_ready(byte_ready),
    .opcode_valid(opcode_valid), .opcode(opcode), .byte_valid(byte_valid),
    .byte_in(byte_in));

  // 125 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Compare of byte-wide values
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Compare of single flags
  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One instruction through decode, operand fetch and execution
  task automatic run_op(input logic [7:0] op, input alu_op_t alu, input src_sel_t src,
                        input dst_sel_t dst, input logic [1:0] len, input logic [1:0] cyc,
                        input int gap);
    logic [7:0] a;
    logic [7:0] b;
    logic [2:0] ri;
    logic       last_done;
    int         n;
    a         = op ^ 8'h5a;
    b         = ~op;
    ri        = (src == SRC_REG || dst == DST_REG) ? op[2:0] : 3'h0;
    last_done = 1'b0;
    fork
      fetch_model_inst.send(op, a, b, int'(len), gap);
      begin
        n = 0;
        @(negedge sys_clk);
        while (!(opcode_valid === 1'b1 && opcode_ready === 1'b1) && n < 50)
        begin
          @(negedge sys_clk);
          n++;
        end
        // Decode shows exactly one cycle after the take
        @(negedge sys_clk);
        check_bit(dec_valid, 1'b1);
        check_bit(known, alu != ALU_NONE);
        check_val(8'(alu_op), 8'(alu));
        check_val(8'(src_sel), 8'(src));
        check_val(8'(dst_sel), 8'(dst));
        check_val(8'(instr_len), 8'(len));
        check_val(8'(exec_cycles), 8'(cyc));
        check_val(8'(reg_index), 8'(ri));
        check_bit(ptr_index, (src == SRC_IND) ? op[0] : 1'b0);
        n = 0;
        while (exec_start !== 1'b1 && n < 50)
        begin
          @(negedge sys_clk);
          n++;
        end
        // Busy length must match the cycle count, done on its last cycle
        n = 0;
        @(negedge sys_clk);
        while (exec_busy === 1'b1 && n < 8)
        begin
          n++;
          last_done = exec_done;
          @(negedge sys_clk);
        end
        check_val(8'(n), 8'(cyc));
        check_bit(last_done, 1'b1);
        check_val(operand1, (len > 2'h1) ? a : 8'h00);
        check_val(operand2, (len > 2'h2) ? b : 8'h00);
      end
    join
  endtask

  // A run of consecutive opcodes sharing one decode
  task automatic rng(input logic [7:0] base, input int cnt, input alu_op_t alu,
                     input src_sel_t src, input dst_sel_t dst, input logic [1:0] len,
                     input logic [1:0] cyc, input int gap);
    for (int i = 0; i < cnt; i++)
      run_op(base + 8'(i), alu, src, dst, len, cyc, gap);
  endtask

  // Arithmetic forms, back to back
  task automatic test_arith();
    rng(8'h28, 8, ALU_ADD, SRC_REG, DST_ACC, LEN_ONE, CYC_ONE, 0);
    rng(8'h25, 1, ALU_ADD, SRC_DIR, DST_ACC, LEN_TWO, CYC_ONE, 0);
    rng(8'h26, 2, ALU_ADD, SRC_IND, DST_ACC, LEN_ONE, CYC_ONE, 0);
    rng(8'h38, 8, ALU_ADD_CY, SRC_REG, DST_ACC, LEN_ONE, CYC_ONE, 0);
    rng(8'h35, 1, ALU_ADD_CY, SRC_DIR, DST_ACC, LEN_TWO, CYC_ONE, 0);
    rng(8'h34, 1, ALU_ADD_CY, SRC_IMM, DST_ACC, LEN_TWO, CYC_ONE, 0);
    rng(8'h98, 8, ALU_SUB_BW, SRC_REG, DST_ACC, LEN_ONE, CYC_ONE, 0);
    rng(8'h95, 1, ALU_SUB_BW, SRC_DIR, DST_ACC, LEN_TWO, CYC_ONE, 0);
    rng(8'h96, 2, ALU_SUB_BW, SRC_IND, DST_ACC, LEN_ONE, CYC_ONE, 0);
    rng(8'h24, 1, ALU_ADD, SRC_IMM, DST_ACC, LEN_TWO, CYC_ONE, 0);
    rng(8'h36, 2, ALU_ADD_CY, SRC_IND, DST_ACC, LEN_ONE, CYC_ONE, 0);
    rng(8'h94, 1, ALU_SUB_BW, SRC_IMM, DST_ACC, LEN_TWO, CYC_ONE, 0);
  endtask

  // Logical forms, three-byte ones included
  task automatic test_logic();
    rng(8'h53, 1, ALU_AND, SRC_IMM, DST_DIR, LEN_THREE, CYC_TWO, 0);
    rng(8'h58, 8, ALU_AND, SRC_REG, DST_ACC, LEN_ONE, CYC_ONE, 0);
    rng(8'h56, 2, ALU_AND, SRC_IND, DST_ACC, LEN_ONE, CYC_ONE, 0);
    rng(8'h54, 1, ALU_AND, SRC_IMM, DST_ACC, LEN_TWO, CYC_ONE, 0);
    rng(8'h52, 1, ALU_AND, SRC_ACC, DST_DIR, LEN_TWO, CYC_ONE, 0);
    rng(8'h43, 1, ALU_OR, SRC_IMM, DST_DIR, LEN_THREE, CYC_TWO, 0);
    rng(8'h48, 8, ALU_OR, SRC_REG, DST_ACC, LEN_ONE, CYC_ONE, 0);
    rng(8'h46, 2, ALU_OR, SRC_IND, DST_ACC, LEN_ONE, CYC_ONE, 0);
    rng(8'h44, 1, ALU_OR, SRC_IMM, DST_ACC, LEN_TWO, CYC_ONE, 0);
    rng(8'h63, 1, ALU_XOR, SRC_IMM, DST_DIR, LEN_THREE, CYC_TWO, 0);
    rng(8'h68, 8, ALU_XOR, SRC_REG, DST_ACC, LEN_ONE, CYC_ONE, 0);
    rng(8'h65, 1, ALU_XOR, SRC_DIR, DST_ACC, LEN_TWO, CYC_ONE, 0);
    rng(8'h66, 2, ALU_XOR, SRC_IND, DST_ACC, LEN_ONE, CYC_ONE, 0);
    rng(8'h55, 1, ALU_AND, SRC_DIR, DST_ACC, LEN_TWO, CYC_ONE, 0);
    rng(8'h45, 1, ALU_OR, SRC_DIR, DST_ACC, LEN_TWO, CYC_ONE, 0);
    rng(8'h42, 1, ALU_OR, SRC_ACC, DST_DIR, LEN_TWO, CYC_ONE, 0);
    rng(8'h64, 1, ALU_XOR, SRC_IMM, DST_ACC, LEN_TWO, CYC_ONE, 0);
    rng(8'h62, 1, ALU_XOR, SRC_ACC, DST_DIR, LEN_TWO, CYC_ONE, 0);
  endtask

  // Rotates through carry, then one opcode outside the table
  task automatic test_rotate();
    rng(8'h33, 1, ALU_ROL_CY, SRC_ACC, DST_ACC, LEN_ONE, CYC_ONE, 0);
    rng(8'h13, 1, ALU_ROR_CY, SRC_ACC, DST_ACC, LEN_ONE, CYC_ONE, 0);
    rng(8'h00, 1, ALU_NONE, SRC_NONE, DST_NONE, LEN_ONE, CYC_ONE, 0);
  endtask

  // Copies with a slow fetch side stalling every unit
  task automatic test_copy();
    rng(8'h86, 2, ALU_COPY, SRC_IND, DST_DIR, LEN_TWO, CYC_TWO, 2);
    rng(8'h85, 1, ALU_COPY, SRC_DIR, DST_DIR, LEN_THREE, CYC_TWO, 3);
    rng(8'ha8, 8, ALU_COPY, SRC_DIR, DST_REG, LEN_TWO, CYC_TWO, 1);
    rng(8'h78, 8, ALU_COPY, SRC_IMM, DST_REG, LEN_TWO, CYC_ONE, 2);
    rng(8'h88, 8, ALU_COPY, SRC_REG, DST_DIR, LEN_TWO, CYC_TWO, 1);
  endtask

  // Counts and verdict; ends the run
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    n_mismatch  = 0;
    check_count = 0;
    rst         = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    test_arith();
    test_logic();
    test_rotate();
    test_copy();
    results();
  end

  // Watchdog, far beyond the roughly 600 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
endmodule
